// file: logic/plsq_pkg.sv
// Purpose: constants and types of the panel power sequencer
// Assumes: core clock of 100 MHz, slow timing from a 1 ms tick
// Notes:   offsets, fields, reset values and timing counts live here
// Behaviour
// - Doze or Sleep holds keyboard gate low
// - keyboard edge or port access raises gate
// - other activity never raises gate in Doze or Sleep
// - keyboard gate glitch free, pulses at least 142ns
// - polarity bit sets supply and bias level
// - panel supply follows mode bit and timer
// - reset clears sequencing bits, sets panel mask
// - auto mode: only sequencer drives panel outputs
// - power-up: supply, isolation, then bias
// - power-down: bias, isolation, then supply
// - Suspend or Off powers panel down in order in auto mode; in manual mode Suspend drops only the supply, Off also clears the delay bits
// - manual: both delay bits drive isolation, bias
// - unmasked panel timer gives interrupt, keeps supply
// - Off entry without auto clears delay bits
// - registers change only on reset or write, delay bits also on Off entry
// - mains disables timers, keyboard restores backlight
// - qualified battery warning interrupts every 15s
// - battery warning debounced, slow or fast
// - supply good rises, output follows after delay
// - supply good loss: drop output, enter Off
package plsq_pkg;

    // ----------------------------------------------------------------
    // register map
    // ----------------------------------------------------------------
    localparam logic [3:0] REG_MISC_SETTINGS  = 4'h0;
    localparam logic [3:0] REG_IRQ_MASK_TWO   = 4'h1;
    localparam logic [3:0] REG_POLARITY       = 4'h2;
    localparam logic [3:0] REG_ON_POWER_CTL   = 4'h3;
    localparam logic [3:0] REG_DOZE_POWER_CTL = 4'h4;
    localparam logic [3:0] REG_STATUS         = 4'h5;
    localparam logic [3:0] REG_BATT_MASK      = 4'h6;

    localparam int BIT_FAST_DEBOUNCE = 7;
    localparam int BIT_AUTO_SEQ      = 4;
    localparam int BIT_DELAY_SEL1    = 3;
    localparam int BIT_DELAY_SEL0    = 2;
    localparam int BIT_PANEL_MASK    = 1;
    localparam int BIT_POLARITY_INV  = 0;
    localparam int BIT_PANEL_POWER   = 0;

    localparam logic [7:0] RST_MISC_SETTINGS = 8'h00;
    localparam logic [7:0] RST_IRQ_MASK_TWO  = 8'h02;
    localparam logic [7:0] RST_POLARITY      = 8'h00;
    localparam logic [7:0] RST_POWER_CTL     = 8'h00;
    localparam logic [7:0] RST_BATT_MASK     = 8'h03;

    // ----------------------------------------------------------------
    // timing
    // ----------------------------------------------------------------
    localparam int CLK_PERIOD_NS   = 10;
    localparam int CLK_HZ          = 100000000;
    localparam int TICK_HZ         = 1000;
    localparam int PULSE_MIN_NS    = 142;
    localparam int PULSE_MIN_CYC   = (PULSE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int KBD_HOLD_MS     = 700;
    localparam int GOOD_DELAY_MS   = 700;
    localparam int DEB_SLOW_MS     = 3000;
    localparam int DEB_FAST_MS     = 45;
    localparam int BATT_REPEAT_MS  = 15000;

    // ----------------------------------------------------------------
    // types
    // ----------------------------------------------------------------
    typedef enum logic [2:0] {
        PLSQ_ON, PLSQ_DOZE, PLSQ_SLEEP, PLSQ_SUSPEND, PLSQ_OFF
    } plsq_mode_t;

    typedef struct packed {
        logic [3:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } plsq_bus_t;

endpackage

// file: logic/plsq_sequencer.sv
// Purpose: keyboard clock gate, panel sequencing, battery and supply good
// Assumes: mode, panel timer and backlight timer come from the same clock
// Notes:   slow timing runs on a 1 ms tick enable
//
// The implementer's own choices: the placing of the registers and strobed register access.
`timescale 1ns/1ps
module plsq_sequencer #(
    parameter int TICK_CYC   = plsq_pkg::CLK_HZ / plsq_pkg::TICK_HZ,
    parameter int SEQ_CYC_0  = 1000000,
    parameter int SEQ_CYC_1  = 2000000,
    parameter int SEQ_CYC_2  = 4000000,
    parameter int SEQ_CYC_3  = 8000000
) (
    // clock and reset
    input  wire logic            core_clk,
    input  wire logic            srst,
    // register port
    input  wire plsq_pkg::plsq_bus_t regBus,
    output logic [7:0]           regRdata,
    // power mode and timers
    input  wire plsq_pkg::plsq_mode_t powerMode,
    input  wire logic            panelTimerExpired,
    input  wire logic            backlightExpired,
    input  wire logic            kbdPortAccess,
    output logic                 timersDisable,
    output logic                 offRequest,
    output logic                 pmIrq,
    // pins
    input  wire logic            kbd_line_clock,
    input  wire logic            supply_good_in,
    input  wire logic            mains_present,
    input  wire logic            battery_warn_1,
    input  wire logic            battery_warn_2,
    output logic                 kbd_clock_gate_n,
    output logic                 panel_supply_ctl,
    output logic                 panel_bias_ctl,
    output logic                 panel_isolation_n,
    output logic                 backlight_supply_ctl,
    output logic                 supply_good_out
);
    import plsq_pkg::*;

    initial begin
        if (TICK_CYC < 2 || SEQ_CYC_0 < 1 || SEQ_CYC_1 < 1 || SEQ_CYC_2 < 1 || SEQ_CYC_3 < 1
            || SEQ_CYC_3 >= (1 << 24))
            $error("plsq_sequencer: parameter out of range");
    end

    // ----------------------------------------------------------------
    // pin synchronisers
    // ----------------------------------------------------------------
    logic [4:0] pinRaw;
    logic [4:0] syncA_q;
    logic [4:0] syncB_q;
    assign pinRaw = {battery_warn_2, battery_warn_1, mains_present, supply_good_in,
                     kbd_line_clock};
    for (genvar i = 0; i < 5; i++) begin : g_sync
        always_ff @(posedge core_clk) begin
            syncA_q[i] <= srst ? 1'b0 : pinRaw[i];
            syncB_q[i] <= srst ? 1'b0 : syncA_q[i];
        end
    end
    logic kbdClk;
    logic goodIn;
    logic mains;
    logic [1:0] battIn;
    assign kbdClk = syncB_q[0];
    assign goodIn = syncB_q[1];
    assign mains  = syncB_q[2];
    assign battIn = syncB_q[4:3];

    // ----------------------------------------------------------------
    // 1 ms timebase
    // ----------------------------------------------------------------
    logic [23:0] tickCnt_q;
    logic        tick;
    assign tick = (tickCnt_q == 24'(TICK_CYC - 1));
    always_ff @(posedge core_clk) begin
        if (srst || tick) tickCnt_q <= 24'h000000;
        else tickCnt_q <= tickCnt_q + 24'h000001;
    end

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    logic [7:0] misc_q;
    logic [7:0] irqMask_q;
    logic [7:0] pol_q;
    logic [7:0] onPwr_q;
    logic [7:0] dozePwr_q;
    logic [7:0] battMask_q;
    logic       wrMisc;
    logic       modeOff;
    logic       modeOff_q;
    logic       offEntry;
    assign wrMisc   = regBus.wr && regBus.addr == REG_MISC_SETTINGS;
    assign modeOff  = powerMode == PLSQ_OFF;
    assign offEntry = modeOff && !modeOff_q;

    always_ff @(posedge core_clk) begin
        if (srst) begin
            misc_q     <= RST_MISC_SETTINGS;
            irqMask_q  <= RST_IRQ_MASK_TWO;
            pol_q      <= RST_POLARITY;
            onPwr_q    <= RST_POWER_CTL;
            dozePwr_q  <= RST_POWER_CTL;
            battMask_q <= RST_BATT_MASK;
            modeOff_q  <= 1'b0;
        end else begin
            modeOff_q <= modeOff;
            // a write in the same cycle beats the hardware clear
            if (wrMisc) misc_q <= regBus.wdata;
            else if (offEntry && !misc_q[BIT_AUTO_SEQ])
                misc_q[BIT_DELAY_SEL1:BIT_DELAY_SEL0] <= 2'b00;
            if (regBus.wr && regBus.addr == REG_IRQ_MASK_TWO) irqMask_q <= regBus.wdata;
            if (regBus.wr && regBus.addr == REG_POLARITY) pol_q <= regBus.wdata;
            if (regBus.wr && regBus.addr == REG_ON_POWER_CTL) onPwr_q <= regBus.wdata;
            if (regBus.wr && regBus.addr == REG_DOZE_POWER_CTL) dozePwr_q <= regBus.wdata;
            if (regBus.wr && regBus.addr == REG_BATT_MASK) battMask_q <= regBus.wdata;
        end
    end

    logic       autoEn;
    logic [1:0] delaySel;
    logic       fastDeb;
    logic       panelMask;
    assign autoEn    = misc_q[BIT_AUTO_SEQ];
    assign delaySel  = misc_q[BIT_DELAY_SEL1:BIT_DELAY_SEL0];
    assign fastDeb   = misc_q[BIT_FAST_DEBOUNCE];
    assign panelMask = irqMask_q[BIT_PANEL_MASK];

    // ----------------------------------------------------------------
    // keyboard clock gate
    // ----------------------------------------------------------------
    logic        kbdClk_q;
    logic        kbdTrig;
    logic        dozeSleep;
    logic [9:0]  kbdHold_q;
    logic        gateWant;
    logic        gate_q;
    logic [4:0]  minCnt_q;
    assign kbdTrig   = (kbdClk_q && !kbdClk) || kbdPortAccess;
    assign dozeSleep = powerMode == PLSQ_DOZE || powerMode == PLSQ_SLEEP;
    // only the keyboard hold can lift the gate inside Doze or Sleep
    assign gateWant  = !dozeSleep || kbdHold_q != 10'h000;

    always_ff @(posedge core_clk) begin
        if (srst) begin
            kbdClk_q  <= 1'b0;
            kbdHold_q <= 10'h000;
            gate_q    <= 1'b1;
            minCnt_q  <= 5'h00;
        end else begin
            kbdClk_q <= kbdClk;
            // one extra tick keeps the hold at or above its figure
            if (kbdTrig) kbdHold_q <= 10'(KBD_HOLD_MS + 1);
            else if (tick && kbdHold_q != 10'h000) kbdHold_q <= kbdHold_q - 10'h001;
            // registered and rate limited, so no glitch and no short pulse
            if (minCnt_q != 5'h00) minCnt_q <= minCnt_q - 5'h01;
            else if (gate_q != gateWant) begin
                gate_q   <= gateWant;
                minCnt_q <= 5'(PULSE_MIN_CYC - 1);
            end
        end
    end
    assign kbd_clock_gate_n = gate_q;

    // ----------------------------------------------------------------
    // panel sequencing
    // ----------------------------------------------------------------
    typedef enum logic [2:0] {
        SQ_DOWN, SQ_UP_ISO, SQ_UP_BIAS, SQ_UP, SQ_DN_ISO, SQ_DN_SUPPLY
    } plsq_seq_t;
    plsq_seq_t   seq_q;
    plsq_seq_t   seq_d;
    logic [23:0] seqCnt_q;
    logic [23:0] seqDelay;
    logic        seqDone;
    logic        modeBit;
    logic        lcdExp;
    logic        panelWant;
    logic        suspOff;
    assign seqDelay  = delaySel == 2'b00 ? 24'(SEQ_CYC_0) :
                       delaySel == 2'b01 ? 24'(SEQ_CYC_1) :
                       delaySel == 2'b10 ? 24'(SEQ_CYC_2) : 24'(SEQ_CYC_3);
    assign seqDone   = seqCnt_q == 24'h000000;
    assign suspOff   = powerMode == PLSQ_SUSPEND || modeOff;
    assign modeBit   = powerMode == PLSQ_ON   ? onPwr_q[BIT_PANEL_POWER] :
                       powerMode == PLSQ_DOZE ? dozePwr_q[BIT_PANEL_POWER] : 1'b0;
    assign lcdExp    = panelTimerExpired && !mains;
    // an unmasked panel timer leaves the supply alone
    assign panelWant = modeBit && !(lcdExp && panelMask) && !suspOff;

    always_comb begin
        seq_d = seq_q;
        unique case (seq_q)
            SQ_DOWN:      if (panelWant) seq_d = SQ_UP_ISO;
            SQ_UP_ISO:    if (!panelWant) seq_d = SQ_DN_SUPPLY;
                          else if (seqDone) seq_d = SQ_UP_BIAS;
            SQ_UP_BIAS:   if (!panelWant) seq_d = SQ_DN_ISO;
                          else if (seqDone) seq_d = SQ_UP;
            SQ_UP:        if (!panelWant) seq_d = SQ_DN_ISO;
            SQ_DN_ISO:    if (seqDone) seq_d = SQ_DN_SUPPLY;
            SQ_DN_SUPPLY: if (seqDone) seq_d = SQ_DOWN;
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (srst || !autoEn) begin
            seq_q    <= SQ_DOWN;
            seqCnt_q <= 24'h000000;
        end else begin
            seq_q <= seq_d;
            if (seq_d != seq_q) seqCnt_q <= seqDelay - 24'h000001;
            else if (!seqDone) seqCnt_q <= seqCnt_q - 24'h000001;
        end
    end

    logic supplyAct;
    logic isoAct;
    logic biasAct;
    logic autoSupply;
    logic autoIso;
    assign autoSupply = seq_q != SQ_DOWN;
    assign autoIso    = seq_q == SQ_UP_BIAS || seq_q == SQ_UP || seq_q == SQ_DN_ISO;
    // auto mode keeps software away from the panel outputs
    assign supplyAct  = autoEn ? autoSupply : panelWant;
    assign isoAct     = autoEn ? autoIso : delaySel == 2'b11;
    assign biasAct    = autoEn ? seq_q == SQ_UP : delaySel == 2'b11;

    logic polInv;
    logic pinSupply_q;
    logic pinBias_q;
    logic pinIso_q;
    assign polInv = pol_q[BIT_POLARITY_INV];
    always_ff @(posedge core_clk) begin
        if (srst) begin
            pinSupply_q <= 1'b0;
            pinBias_q   <= 1'b0;
            pinIso_q    <= 1'b1;
        end else begin
            pinSupply_q <= supplyAct ^ polInv;
            pinBias_q   <= biasAct ^ polInv;
            pinIso_q    <= !isoAct;
        end
    end
    assign panel_supply_ctl  = pinSupply_q;
    assign panel_bias_ctl    = pinBias_q;
    assign panel_isolation_n = pinIso_q;

    // ----------------------------------------------------------------
    // mains and backlight
    // ----------------------------------------------------------------
    logic blOff_q;
    always_ff @(posedge core_clk) begin
        if (srst) blOff_q <= 1'b0;
        else if (kbdTrig) blOff_q <= 1'b0;
        else if (backlightExpired) blOff_q <= 1'b1;
    end
    assign backlight_supply_ctl = !blOff_q;
    assign timersDisable        = mains;

    // ----------------------------------------------------------------
    // battery warnings
    // ----------------------------------------------------------------
    logic [1:0]  battQual;
    logic [1:0]  battIrq;
    logic [11:0] debTarget;
    assign debTarget = fastDeb ? 12'(DEB_FAST_MS) : 12'(DEB_SLOW_MS);
    for (genvar b = 0; b < 2; b++) begin : g_batt
        logic [11:0] debCnt_q;
        logic [13:0] repCnt_q;
        logic        qual_q;
        always_ff @(posedge core_clk) begin
            if (srst || !battIn[b]) begin
                debCnt_q <= 12'h000;
                qual_q   <= 1'b0;
            end else if (tick) begin
                // any low restarts the count
                if (debCnt_q >= debTarget) qual_q <= 1'b1;
                else debCnt_q <= debCnt_q + 12'h001;
            end
        end
        always_ff @(posedge core_clk) begin
            if (srst || !qual_q || battMask_q[b] || suspOff) repCnt_q <= 14'h0000;
            else if (tick) begin
                if (repCnt_q == 14'(BATT_REPEAT_MS - 1)) repCnt_q <= 14'h0000;
                else repCnt_q <= repCnt_q + 14'h0001;
            end
        end
        // first interrupt on qualification, then every repeat period
        assign battIrq[b] = qual_q && !battMask_q[b] && !suspOff && tick
                            && repCnt_q == 14'h0000;
        assign battQual[b] = qual_q;
    end

    // ----------------------------------------------------------------
    // interrupt pulse
    // ----------------------------------------------------------------
    logic lcdExp_q;
    logic lcdIrq;
    logic irq_q;
    assign lcdIrq = lcdExp && !lcdExp_q && !panelMask;
    always_ff @(posedge core_clk) begin
        if (srst) begin
            lcdExp_q <= 1'b0;
            irq_q    <= 1'b0;
        end else begin
            lcdExp_q <= lcdExp;
            irq_q    <= lcdIrq || |battIrq;
        end
    end
    assign pmIrq = irq_q;

    // ----------------------------------------------------------------
    // supply good handshake
    // ----------------------------------------------------------------
    logic        goodIn_q;
    logic [9:0]  goodCnt_q;
    logic        goodWait_q;
    logic        goodOut_q;
    logic        offReq_q;
    logic        goodFall;
    assign goodFall = goodIn_q && !goodIn;
    always_ff @(posedge core_clk) begin
        if (srst) begin
            goodIn_q   <= 1'b0;
            goodCnt_q  <= 10'h000;
            goodWait_q <= 1'b0;
            goodOut_q  <= 1'b0;
            offReq_q   <= 1'b0;
        end else begin
            goodIn_q <= goodIn;
            offReq_q <= goodFall && !suspOff;
            if (!goodIn || suspOff) begin
                // commanded Suspend or Off drops the output first
                goodOut_q  <= 1'b0;
                goodWait_q <= 1'b0;
            end else if (!goodIn_q) begin
                goodWait_q <= 1'b1;
                goodCnt_q  <= 10'(GOOD_DELAY_MS + 1);
            end else if (goodWait_q && tick) begin
                if (goodCnt_q == 10'h001) begin
                    goodOut_q  <= 1'b1;
                    goodWait_q <= 1'b0;
                end
                goodCnt_q <= goodCnt_q - 10'h001;
            end
        end
    end
    assign supply_good_out = goodOut_q;
    assign offRequest      = offReq_q;

    // ----------------------------------------------------------------
    // read port
    // ----------------------------------------------------------------
    logic [7:0] rdMux;
    logic [7:0] statusWord;
    assign statusWord = {battQual, blOff_q, goodOut_q, biasAct, isoAct, supplyAct, gate_q};
    assign rdMux = regBus.addr == REG_MISC_SETTINGS  ? misc_q :
                   regBus.addr == REG_IRQ_MASK_TWO   ? irqMask_q :
                   regBus.addr == REG_POLARITY       ? pol_q :
                   regBus.addr == REG_ON_POWER_CTL   ? onPwr_q :
                   regBus.addr == REG_DOZE_POWER_CTL ? dozePwr_q :
                   regBus.addr == REG_STATUS         ? statusWord :
                   regBus.addr == REG_BATT_MASK      ? battMask_q : 8'h00;
    always_ff @(posedge core_clk) begin
        if (srst) regRdata <= 8'h00;
        else if (regBus.rd) regRdata <= rdMux;
        else regRdata <= 8'h00;
    end

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (srst);

    AST_GATE_LOW: assert property (minCnt_q == 5'h00 && !gateWant |=> !gate_q)
        else $error("keyboard gate not low in Doze or Sleep");
    AST_GATE_HOLD: assert property (kbdTrig |=> kbdHold_q == 10'(KBD_HOLD_MS + 1))
        else $error("keyboard hold not loaded");
    AST_GATE_WIDTH: assert property ($rose(gate_q) |=> gate_q[*8])
        else $error("keyboard gate pulse too short");
    AST_POLARITY: assert property (##1 panel_supply_ctl == ($past(supplyAct) ^ $past(polInv)))
        else $error("panel supply level wrong");
    AST_UP_ORDER: assert property (autoEn && $rose(autoSupply) |-> !autoIso ##1 !autoIso)
        else $error("isolation before supply delay");
    AST_DN_ORDER: assert property (autoEn && $fell(biasAct) |-> isoAct && supplyAct)
        else $error("bias not first off");
    AST_MANUAL: assert property (!autoEn && delaySel == 2'b11
                                 |=> !pinIso_q && pinBias_q == !$past(polInv))
        else $error("manual isolation or bias not active");
    AST_OFF_CLEAR: assert property (offEntry && !autoEn && !wrMisc |=> delaySel == 2'b00)
        else $error("delay select not cleared on Off");
    AST_GOOD_DROP: assert property (goodFall && !suspOff |=> !goodOut_q && offReq_q)
        else $error("supply good not dropped");

    COV_KBD: cover property (dozeSleep && kbdTrig ##1 gate_q);
    COV_SEQ_UP: cover property (seq_q == SQ_UP_BIAS ##1 seq_q == SQ_UP);
    COV_GOOD: cover property ($rose(goodOut_q));
    COV_BATT: cover property (|battIrq);

endmodule // plsq_sequencer

// file: sim/plsq_supply_model.sv
// Purpose: supply, battery comparators and keyboard line seen by the sequencer
// Assumes: commands from the bench, one per cycle
// Notes:   keyboard line idles high, as its pull-up leaves it
`timescale 1ns/1ps
module plsq_supply_model (
    // clock and commands
    input  wire logic core_clk,
    input  wire logic railOn,
    input  wire logic onAc,
    input  wire logic [1:0] battLow,
    input  wire logic kbdTap,
    // pins toward the sequencer
    output logic      supply_good_in,
    output logic      mains_present,
    output logic      battery_warn_1,
    output logic      battery_warn_2,
    output logic      kbd_line_clock
);
    always_ff @(posedge core_clk) begin
        supply_good_in <= railOn;
        mains_present  <= onAc;
        battery_warn_1 <= battLow[0];
        battery_warn_2 <= battLow[1];
        kbd_line_clock <= ~kbdTap;
    end
endmodule // plsq_supply_model

// file: sim/testbench.sv
// Purpose: self-checking bench of the panel power sequencer
// Assumes: 1 ms tick shortened to 10 cycles, delays 5/10/15/20 cycles
// Notes:   battery repeat period too long for one run, first warning only
`timescale 1ns/1ps
module testbench;
    import plsq_pkg::*;
    logic core_clk = 1'b0, srst = 1'b1, kbdPortAccess = 1'b0, panelExp = 1'b0, blExp = 1'b0;
    logic railOn = 1'b0, onAc = 1'b0, kbdTap = 1'b0;
    logic [1:0] battLow = 2'b00;
    plsq_bus_t bus = '0;
    plsq_mode_t mode = PLSQ_ON;
    logic [7:0] rdata, v;
    logic gd, mp, w1, w2, kc, gate, sup, bias, isoN, goodOut, offReq, irq, tDis, bl;
    int fails = 0, total_checks = 0, cycles = 0;

    plsq_sequencer #(.TICK_CYC(10), .SEQ_CYC_0(5), .SEQ_CYC_1(10), .SEQ_CYC_2(15),
        .SEQ_CYC_3(20)) i_plsq_sequencer (.core_clk(core_clk), .srst(srst),
        .regBus(bus), .regRdata(rdata), .powerMode(mode), .panelTimerExpired(panelExp),
        .backlightExpired(blExp), .kbdPortAccess(kbdPortAccess), .timersDisable(tDis),
        .offRequest(offReq), .pmIrq(irq), .kbd_line_clock(kc), .supply_good_in(gd),
        .mains_present(mp), .battery_warn_1(w1), .battery_warn_2(w2),
        .kbd_clock_gate_n(gate), .panel_supply_ctl(sup), .panel_bias_ctl(bias),
        .panel_isolation_n(isoN), .backlight_supply_ctl(bl), .supply_good_out(goodOut));
    plsq_supply_model i_plsq_supply_model (.core_clk(core_clk), .railOn(railOn),
        .onAc(onAc), .battLow(battLow), .kbdTap(kbdTap), .supply_good_in(gd),
        .mains_present(mp), .battery_warn_1(w1), .battery_warn_2(w2),
        .kbd_line_clock(kc));

    always #5 core_clk = ~core_clk;
    // ceiling well above the ~15k cycles the tests need
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 40000) begin
            fails++;
            stop_test();
        end
    end

    task automatic stop_test();
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic chk(input bit ok, input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (!ok) begin
            fails++;
            $display("ERROR t=%0t got %0h exp %0h", $time, got, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge core_clk) bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge core_clk) bus <= '0;
    endtask
    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge core_clk) bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge core_clk) bus <= '0;
        #1 d = rdata;
    endtask
    task automatic rdchk(input logic [3:0] a, input logic [7:0] e);
        rd(a, v);
        chk(v === e, v, e);
    endtask

    task automatic t_reset();
        rdchk(REG_MISC_SETTINGS, 8'h00);
        rdchk(REG_IRQ_MASK_TWO, 8'h02);
        rdchk(4'h7, 8'h00);
        chk({sup, bias, isoN, goodOut} === 4'h2, {sup, bias, isoN, goodOut}, 4'h2);
        $display("test reset done");
    endtask
    task automatic t_manual();
        wr(REG_MISC_SETTINGS, 8'h0C);
        cyc(3);
        chk({isoN, bias} === 2'b01, {isoN, bias}, 2'b01);
        wr(REG_ON_POWER_CTL, 8'h01);
        cyc(3);
        chk(sup === 1'b1, sup, 1);
        wr(REG_IRQ_MASK_TWO, 8'h00);
        panelExp <= 1'b1;
        cyc(1);
        chk({irq, sup} === 2'b11, {irq, sup}, 3);
        wr(REG_IRQ_MASK_TWO, 8'h02);
        cyc(3);
        chk(sup === 1'b0, sup, 0);
        panelExp <= 1'b0;
        wr(REG_POLARITY, 8'h01);
        cyc(3);
        chk({sup, bias} === 2'b00, {sup, bias}, 0);
        wr(REG_ON_POWER_CTL, 8'h00);
        wr(REG_POLARITY, 8'h00);
        mode <= PLSQ_OFF;
        cyc(3);
        rdchk(REG_MISC_SETTINGS, 8'h00);
        mode <= PLSQ_ON;
        $display("test manual done");
    endtask
    task automatic t_auto();
        int t[3];
        int d1, d2;
        wr(REG_MISC_SETTINGS, 8'h10);
        wr(REG_MISC_SETTINGS, 8'h14);
        for (int p = 0; p < 2; p++) begin
            t = '{-1, -1, -1};
            if (p == 0) wr(REG_ON_POWER_CTL, 8'h01);
            else mode <= PLSQ_SUSPEND;
            for (int i = 0; i < 80; i++) begin
                cyc(1);
                if (t[0] < 0 && sup === !p) t[0] = i;
                if (t[1] < 0 && isoN === p) t[1] = i;
                if (t[2] < 0 && bias === !p) t[2] = i;
            end
            // up: supply, isolation, bias; down the reverse, 10 cycles apart
            d1 = p ? t[1] - t[2] : t[1] - t[0];
            d2 = p ? t[0] - t[1] : t[2] - t[1];
            chk(d1 >= 10 && d1 <= 11, d1, 10);
            chk(d2 >= 10 && d2 <= 11, d2, 10);
        end
        // clear the mode bit first, so On does not start a new power-up
        wr(REG_ON_POWER_CTL, 8'h00);
        mode <= PLSQ_ON;
        $display("test auto done");
    endtask
    task automatic t_kbd();
        mode <= PLSQ_DOZE;
        cyc(40);
        chk(gate === 1'b0, gate, 0);
        onAc <= 1'b1;
        cyc(40);
        chk(gate === 1'b0 && tDis === 1'b1, {gate, tDis}, 1);
        onAc <= 1'b0;
        blExp <= 1'b1;
        cyc(2);
        blExp <= 1'b0;
        chk(bl === 1'b0, bl, 0);
        kbdPortAccess <= 1'b1;
        cyc(1);
        kbdPortAccess <= 1'b0;
        cyc(6800);
        chk(gate === 1'b1, gate, 1);
        chk(bl === 1'b1, bl, 1);
        cyc(400);
        chk(gate === 1'b0, gate, 0);
        kbdTap <= 1'b1;
        cyc(3);
        kbdTap <= 1'b0;
        cyc(40);
        chk(gate === 1'b1, gate, 1);
        mode <= PLSQ_ON;
        $display("test keyboard done");
    endtask
    task automatic t_good();
        int n = -1;
        railOn <= 1'b1;
        cyc(6900);
        chk(goodOut === 1'b0, goodOut, 0);
        cyc(300);
        chk(goodOut === 1'b1, goodOut, 1);
        railOn <= 1'b0;
        for (int i = 0; i < 8; i++) begin
            cyc(1);
            if (n < 0 && offReq === 1'b1) n = i;
        end
        chk(n >= 0 && goodOut === 1'b0, n, 0);
        $display("test supply good done");
    endtask
    task automatic t_batt();
        int n = -1;
        wr(REG_MISC_SETTINGS, 8'h80);
        // first warning masked, so only the second one may interrupt
        wr(REG_BATT_MASK, 8'h01);
        battLow <= 2'b11;
        for (int i = 0; i < 900 && n < 0; i++) begin
            cyc(1);
            if (irq === 1'b1) n = i;
        end
        chk(n >= 440 && n <= 480, n, 450);
        rdchk(REG_STATUS, 8'hC1);
        $display("test battery done");
    endtask

    initial begin
        cyc(12);
        srst <= 1'b0;
        cyc(1);
        t_reset();
        t_manual();
        t_auto();
        t_kbd();
        t_good();
        t_batt();
        stop_test();
    end
endmodule // testbench
